/* rtl/sss_regs.svh */
// register map, field positions and timing figures of the safety supervisor
`ifndef SSS_REGS_SVH
`define SSS_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSS_OFF_KICK      8'h00
`define SSS_OFF_STATUS    8'h04
`define SSS_OFF_IRQ_STAT  8'h08
`define SSS_OFF_IRQ_MASK  8'h0c
// ----------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------
`define SSS_ST_ONLINE     0
`define SSS_ST_RUNNING    1
`define SSS_ST_MAINS      2
`define SSS_ST_BATT_LOW   3
`define SSS_ST_ABORTED    4
`define SSS_ST_REFUSED    5
`define SSS_ST_FAILED     7
// ----------------------------------------------------------------
// interrupt bits
// ----------------------------------------------------------------
`define SSS_IRQ_WDOG      0
`define SSS_IRQ_REFUSE    1
`define SSS_IRQ_SHUT      2
`define SSS_IRQ_W         3
// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define SSS_CLK_HZ        250000000
`define SSS_KICK_MS       20
`define SSS_WDOG_TMO_MS   40
`define SSS_SHUT_S        10
`define SSS_SLOW_MHZ      500
`define SSS_FAST_MHZ      5000
`define SSS_RESTART_CYC   16
`define SSS_WDOG_CYC      ((`SSS_CLK_HZ / 1000) * `SSS_WDOG_TMO_MS)
`define SSS_SHUT_CYC      (`SSS_CLK_HZ * `SSS_SHUT_S)
`define SSS_SLOW_HALF_CYC ((`SSS_CLK_HZ / 2 / `SSS_SLOW_MHZ) * 1000)
`define SSS_FAST_HALF_CYC ((`SSS_CLK_HZ / 2 / `SSS_FAST_MHZ) * 1000)
`endif

/* rtl/sss_pkg.sv */
// types shared by the safety supervisor files
package sss_pkg;
    typedef enum logic [1:0] {
        SSS_ST_RUN   = 2'b00,
        SSS_ST_WDRST = 2'b01,
        SSS_ST_SHUT  = 2'b10
    } sss_state_t;

    typedef enum logic [7:0] {
        SSS_CMD_NOP                  = 8'h00,
        SSS_CMD_STATUS_QUERY_COMMAND = 8'h01,
        SSS_CMD_GO_ONLINE            = 8'h02,
        SSS_CMD_GO_OFFLINE           = 8'h03,
        SSS_CMD_START_SEQ            = 8'h04
    } sss_cmd_t;
endpackage

/* rtl/sss_timer.sv */
// elapsed-time counter with clear, run and terminal-count pulse
module sss_timer #(
    parameter int unsigned W     = 32,
    parameter int unsigned LIMIT = 16
) (
    input  wire logic i_core_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_clr,
    input  wire logic i_run,
    output logic      o_hit
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    initial begin
        if (LIMIT < 1 || W > 32 || (W < 32 && LIMIT > (32'h1 << W))) begin
            $error("sss_timer: limit does not fit counter width");
        end
    end

    // ----------------------------------------------------------------
    // counting
    // ----------------------------------------------------------------
    // hit fires on the last cycle and the count restarts, so a held run repeats
    assign o_hit = i_run && !i_clr && (cnt_r == W'(LIMIT - 1));

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_clr || o_hit) begin
            cnt_nxt = '0;
        end else if (i_run) begin
            cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (i_ce) begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule // sss_timer

/* rtl/sss_supervisor.sv */
// watchdog, power-fail and indicator supervisor with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`include "sss_regs.svh"

// Summary of operation
// - firmware restarts the watchdog every 20 ms so it never expires.
// - watchdog expiry asserts the hardware reset and forces every other output inactive except the interrupt.
// - after the restart sequence the unit returns online with failure flag set.
// - a status query is answered with the status word, bit 7 (128) set after a failure.
// - abort indicator is active while online and not aborted.
// - mains failure while online and idle keeps online but refuses starts.
// - mains failure during a running sequence lets it run to completion.
// - mains failure while offline shuts the unit down after 10 seconds.
// - power indicator steady on with mains present and battery not low.
// - power indicator blinks at 0.5 Hz with mains present and battery low.
// - power indicator blinks at 5 Hz without mains and with battery low.
// - on battery, online and battery not low, shut down 10 seconds after the last command.
module sss_supervisor
    import sss_pkg::*;
#(
    parameter int unsigned WDOG_CYC      = `SSS_WDOG_CYC,
    parameter int unsigned SHUT_CYC      = `SSS_SHUT_CYC,
    parameter int unsigned SLOW_HALF_CYC = `SSS_SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYC = `SSS_FAST_HALF_CYC,
    parameter int unsigned RESTART_CYC   = `SSS_RESTART_CYC
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        i_cmd_valid,
    input  wire logic [7:0]  i_cmd_code,
    output logic             o_rsp_valid,
    output logic [7:0]       o_rsp_status,
    input  wire logic        i_mains_ok,
    input  wire logic        i_batt_low,
    input  wire logic        i_abort_sw,
    input  wire logic        i_seq_done,
    output logic             o_seq_start,
    output logic             o_seq_running,
    output logic             o_out_en,
    output logic             o_hw_rst,
    output logic             o_online,
    output logic             o_abort_ind,
    output logic             o_power_led,
    output logic             o_shutdown,
    output logic             o_irq
);
    localparam int unsigned RW = 8;

    initial begin
        if (RESTART_CYC < 1 || RESTART_CYC > 255 || SLOW_HALF_CYC < 1 || FAST_HALF_CYC < 1) begin
            $error("sss_supervisor: unsupported timing parameters");
        end
    end

    // byte address compare on the word, low two bits ignored
    function automatic logic hit_off(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction

    sss_state_t   state_r, state_nxt;
    logic [RW-1:0] rst_cnt_r, rst_cnt_nxt;
    logic         online_r, online_nxt, run_r, run_nxt, abort_r, abort_nxt;
    logic         fail_r, fail_nxt, refused_r, refused_nxt;
    logic         start_r, start_nxt, rsp_v_r, rsp_v_nxt;
    logic [7:0]   rsp_r, rsp_nxt, status_w;
    logic [`SSS_IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
    logic         bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]   bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0]  rdata_r, rdata_nxt;
    logic         wr_go, rd_go, kick, wd_hit, sh_hit, sh_run, sh_clr;
    logic         is_cmd, cmd_query, cmd_on, cmd_off, cmd_start, start_ok;
    logic         led_r, led_nxt;
    logic [31:0]  blink_r, blink_nxt;

    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    // address and data are taken together; both wait while a response is pending
    assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bv_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign rd_go         = s_axi_arvalid && !rv_r;
    assign s_axi_arready = rd_go;
    assign kick          = wr_go && i_ce && hit_off(s_axi_awaddr, `SSS_OFF_KICK);

    always_comb begin
        bv_nxt    = bv_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rv_nxt    = rv_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (wr_go) begin
            bv_nxt    = 1'b1;
            bresp_nxt = 2'b00;
            if (!hit_off(s_axi_awaddr, `SSS_OFF_KICK) &&
                !hit_off(s_axi_awaddr, `SSS_OFF_STATUS) &&
                !hit_off(s_axi_awaddr, `SSS_OFF_IRQ_STAT) &&
                !hit_off(s_axi_awaddr, `SSS_OFF_IRQ_MASK)) begin
                bresp_nxt = 2'b11;
            end
        end
        if (rd_go) begin
            rv_nxt    = 1'b1;
            rresp_nxt = 2'b00;
            rdata_nxt = '0;
            if (hit_off(s_axi_araddr, `SSS_OFF_STATUS)) begin
                rdata_nxt = {24'h0, status_w};
            end else if (hit_off(s_axi_araddr, `SSS_OFF_IRQ_STAT)) begin
                rdata_nxt = {29'h0, ist_r};
            end else if (hit_off(s_axi_araddr, `SSS_OFF_IRQ_MASK)) begin
                rdata_nxt = {29'h0, imask_r};
            end else if (!hit_off(s_axi_araddr, `SSS_OFF_KICK)) begin
                rresp_nxt = 2'b11;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bv_r    <= 1'b0;
            bresp_r <= 2'b00;
            rv_r    <= 1'b0;
            rresp_r <= 2'b00;
            rdata_r <= 32'h0;
        end else if (i_ce) begin
            bv_r    <= bv_nxt;
            bresp_r <= bresp_nxt;
            rv_r    <= rv_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign s_axi_bvalid = bv_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rv_r;
    assign s_axi_rresp  = rresp_r;
    assign s_axi_rdata  = rdata_r;

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    sss_timer #(.W(32), .LIMIT(WDOG_CYC)) u_wdog (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_clr      (kick),
        .i_run      (state_r == SSS_ST_RUN),
        .o_hit      (wd_hit)
    );

    // shutdown clock runs on battery unless a sequence must finish or the unit is online with a low battery
    assign sh_run = state_r == SSS_ST_RUN && !i_mains_ok && !run_r &&
                    (!online_r || !i_batt_low);
    assign sh_clr = i_mains_ok || (is_cmd && online_r);

    sss_timer #(.W(32), .LIMIT(SHUT_CYC)) u_shut (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_clr      (sh_clr),
        .i_run      (sh_run),
        .o_hit      (sh_hit)
    );

    // ----------------------------------------------------------------
    // command decode and supervisor state
    // ----------------------------------------------------------------
    assign is_cmd    = i_cmd_valid && state_r == SSS_ST_RUN;
    assign cmd_query = is_cmd && i_cmd_code == SSS_CMD_STATUS_QUERY_COMMAND;
    assign cmd_on    = is_cmd && i_cmd_code == SSS_CMD_GO_ONLINE;
    assign cmd_off   = is_cmd && i_cmd_code == SSS_CMD_GO_OFFLINE;
    assign cmd_start = is_cmd && i_cmd_code == SSS_CMD_START_SEQ;
    // no start without mains: a battery may not carry a whole new sequence
    assign start_ok  = online_r && !abort_r && !run_r && i_mains_ok;

    always_comb begin
        status_w = '0;
        status_w[`SSS_ST_ONLINE]   = online_r;
        status_w[`SSS_ST_RUNNING]  = run_r;
        status_w[`SSS_ST_MAINS]    = i_mains_ok;
        status_w[`SSS_ST_BATT_LOW] = i_batt_low;
        status_w[`SSS_ST_ABORTED]  = abort_r;
        status_w[`SSS_ST_REFUSED]  = refused_r;
        status_w[`SSS_ST_FAILED]   = fail_r;
    end

    always_comb begin
        state_nxt   = state_r;
        rst_cnt_nxt = rst_cnt_r;
        online_nxt  = online_r;
        run_nxt     = run_r;
        abort_nxt   = abort_r || i_abort_sw;
        fail_nxt    = fail_r;
        refused_nxt = refused_r;
        start_nxt   = 1'b0;
        rsp_v_nxt   = 1'b0;
        rsp_nxt     = rsp_r;
        case (state_r)
            SSS_ST_RUN: begin
                if (wd_hit) begin
                    // everything drops at once; only the failure record survives
                    state_nxt   = SSS_ST_WDRST;
                    rst_cnt_nxt = '0;
                    online_nxt  = 1'b0;
                    run_nxt     = 1'b0;
                    abort_nxt   = 1'b0;
                    refused_nxt = 1'b0;
                    rsp_nxt     = '0;
                end else if (sh_hit) begin
                    state_nxt  = SSS_ST_SHUT;
                    online_nxt = 1'b0;
                    run_nxt    = 1'b0;
                end else begin
                    // mains state does not stop a running sequence
                    if (i_seq_done || i_abort_sw) begin
                        run_nxt = 1'b0;
                    end
                    if (cmd_on) begin
                        online_nxt = 1'b1;
                        abort_nxt  = i_abort_sw;
                    end
                    if (cmd_off) begin
                        online_nxt = 1'b0;
                    end
                    if (cmd_start) begin
                        start_nxt   = start_ok;
                        run_nxt     = run_r || start_ok;
                        refused_nxt = !start_ok;
                    end
                    if (cmd_query) begin
                        rsp_v_nxt = 1'b1;
                        rsp_nxt   = status_w;
                    end
                end
            end
            SSS_ST_WDRST: begin
                abort_nxt   = 1'b0;
                rst_cnt_nxt = rst_cnt_r + RW'(1);
                if (rst_cnt_r == RW'(RESTART_CYC - 1)) begin
                    state_nxt  = SSS_ST_RUN;
                    online_nxt = 1'b1;
                    fail_nxt   = 1'b1;
                    abort_nxt  = i_abort_sw; // a switch held through restart stays honoured
                end
            end
            SSS_ST_SHUT: begin
                abort_nxt = abort_r;
            end
            default: begin
                state_nxt = SSS_ST_RUN;
            end
        endcase
        // software acknowledges the failure by writing one to bit 7 of status
        if (wr_go && hit_off(s_axi_awaddr, `SSS_OFF_STATUS) && s_axi_wstrb[0] &&
            s_axi_wdata[`SSS_ST_FAILED] && state_r == SSS_ST_RUN) begin
            fail_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r   <= SSS_ST_RUN;
            rst_cnt_r <= '0;
            online_r  <= 1'b0;
            run_r     <= 1'b0;
            abort_r   <= 1'b0;
            fail_r    <= 1'b0;
            refused_r <= 1'b0;
            start_r   <= 1'b0;
            rsp_v_r   <= 1'b0;
            rsp_r     <= 8'h00;
        end else if (i_ce) begin
            state_r   <= state_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            online_r  <= online_nxt;
            run_r     <= run_nxt;
            abort_r   <= abort_nxt;
            fail_r    <= fail_nxt;
            refused_r <= refused_nxt;
            start_r   <= start_nxt;
            rsp_v_r   <= rsp_v_nxt;
            rsp_r     <= rsp_nxt;
        end
    end

    assign o_seq_start   = start_r;
    assign o_seq_running = run_r;
    assign o_rsp_valid   = rsp_v_r;
    assign o_rsp_status  = rsp_r;
    assign o_online      = online_r;
    assign o_out_en      = state_r == SSS_ST_RUN;
    assign o_hw_rst      = state_r == SSS_ST_WDRST;
    assign o_shutdown    = state_r == SSS_ST_SHUT;
    assign o_abort_ind   = online_r && !abort_r;

    // ----------------------------------------------------------------
    // power indicator
    // ----------------------------------------------------------------
    // blink phase counter restarts on every toggle; a rate change applies to the phase in progress, steady and off at once
    always_comb begin
        led_nxt   = led_r;
        blink_nxt = blink_r + 32'h1;
        if (state_nxt != SSS_ST_RUN || (!i_mains_ok && !i_batt_low)) begin
            led_nxt   = 1'b0;
            blink_nxt = '0;
        end else if (!i_batt_low) begin
            led_nxt   = 1'b1;
            blink_nxt = '0;
        end else if (i_mains_ok && blink_r >= SLOW_HALF_CYC - 1) begin
            led_nxt   = !led_r;
            blink_nxt = '0;
        end else if (!i_mains_ok && blink_r >= FAST_HALF_CYC - 1) begin
            led_nxt   = !led_r;
            blink_nxt = '0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            led_r   <= 1'b0;
            blink_r <= 32'h0;
        end else if (i_ce) begin
            led_r   <= led_nxt;
            blink_r <= blink_nxt;
        end
    end

    assign o_power_led = led_r;

    // ----------------------------------------------------------------
    // interrupts
    // ----------------------------------------------------------------
    assign ev = {sh_hit && state_r == SSS_ST_RUN && !wd_hit,
                 cmd_start && !start_ok && !wd_hit && !sh_hit,
                 wd_hit && state_r == SSS_ST_RUN};

    // a new event wins over a write-one clear in the same cycle
    always_comb begin
        ist_nxt   = ist_r | ev;
        imask_nxt = imask_r;
        if (wr_go && hit_off(s_axi_awaddr, `SSS_OFF_IRQ_STAT) && s_axi_wstrb[0]) begin
            ist_nxt = (ist_r & ~s_axi_wdata[`SSS_IRQ_W-1:0]) | ev;
        end
        if (wr_go && hit_off(s_axi_awaddr, `SSS_OFF_IRQ_MASK) && s_axi_wstrb[0]) begin
            imask_nxt = s_axi_wdata[`SSS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ist_r   <= '0;
            imask_r <= '0;
        end else if (i_ce) begin
            ist_r   <= ist_nxt;
            imask_r <= imask_nxt;
        end
    end

    assign o_irq = |(ist_r & imask_r);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_expire;
        i_ce && state_r == SSS_ST_RUN && wd_hit;
    endsequence
    sequence s_query;
        i_ce && cmd_query && !wd_hit && !sh_hit;
    endsequence

    property p_kick_holds;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && kick && state_r == SSS_ST_RUN) |=> state_r != SSS_ST_WDRST;
    endproperty
    a_kick_holds: assert property (p_kick_holds) else $error("kick did not hold off");

    property p_expire;
        @(posedge i_core_clk) disable iff (i_rst)
        s_expire |=> (o_hw_rst && !o_out_en && !o_online && !o_abort_ind &&
                      !o_seq_running && !o_power_led);
    endproperty
    a_expire: assert property (p_expire) else $error("expiry left outputs active");

    property p_return;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_r == SSS_ST_RUN && $past(state_r) == SSS_ST_WDRST) |-> (online_r && fail_r);
    endproperty
    a_return: assert property (p_return) else $error("restart not online with flag");

    property p_query;
        @(posedge i_core_clk) disable iff (i_rst)
        s_query |=> (o_rsp_valid && o_rsp_status == $past(status_w));
    endproperty
    a_query: assert property (p_query) else $error("status query not answered");

    property p_flag_bit;
        @(posedge i_core_clk) disable iff (i_rst)
        (o_rsp_valid && $past(fail_r)) |-> o_rsp_status[7];
    endproperty
    a_flag_bit: assert property (p_flag_bit) else $error("failure flag not in bit 7");

    property p_abort;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && i_abort_sw) |=> !o_abort_ind;
    endproperty
    a_abort: assert property (p_abort) else $error("abort indicator stayed active");

    property p_refuse;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && cmd_start && !i_mains_ok) |=> !o_seq_start;
    endproperty
    a_refuse: assert property (p_refuse) else $error("start taken without mains");

    property p_keep_running;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && run_r && !i_seq_done && !i_abort_sw && !wd_hit && state_r == SSS_ST_RUN)
            |=> o_seq_running;
    endproperty
    a_keep_running: assert property (p_keep_running) else $error("sequence dropped");

    property p_shut;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && sh_hit && !wd_hit && state_r == SSS_ST_RUN) |=> o_shutdown;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown after timeout");

    property p_led_on;
        @(posedge i_core_clk) disable iff (i_rst)
        (i_ce && state_r == SSS_ST_RUN && !wd_hit && !sh_hit && i_mains_ok && !i_batt_low)
            |=> o_power_led;
    endproperty
    a_led_on: assert property (p_led_on) else $error("power indicator not steady");
endmodule // sss_supervisor

/* dv/sss_host_model.sv */
// host side of the command link: sends commands, keeps the last status answer
module sss_host_model
    import sss_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rsp_valid,
    input  wire logic [7:0] i_rsp_status,
    output logic            o_cmd_valid,
    output logic [7:0]      o_cmd_code,
    output logic [7:0]      o_last
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_cmd_valid = 1'b0;
    initial o_cmd_code = 8'h00;
    initial o_last = 8'h00;
    // one-cycle strobe; code flips after so a stale code never looks valid
    task automatic send(input sss_cmd_t c);
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b1;
        o_cmd_code  <= c;
        @(posedge i_core_clk);
        o_cmd_valid <= 1'b0;
        o_cmd_code  <= ~c;
    endtask
    // keep the answer word, it stands only one cycle
    always @(posedge i_core_clk) if (i_rsp_valid) o_last <= i_rsp_status;
endmodule // sss_host_model

/* dv/test_sss_supervisor.sv */
// self-checking bench of the safety supervisor
module test_sss_supervisor
    import sss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WD = 1000;
    localparam int SH = 300;
    logic clk = 0, rst = 1, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, lq = 0;
    logic mains = 1, low = 0, abt = 0, done = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [1:0] rsp;
    int bad_count = 0, check_count = 0, starts = 0, tog = 0, hrc = 0, n0, s0;
    int hf[3] = '{0, 20, 6};
    wire awr, wrd, bv, arr, rv, cv, rsv, st, run, oe, hr, onl, ai, led, sd, irq;
    wire [1:0] br, rr2;
    wire [31:0] rdt;
    wire [7:0] cc, rss, last;
    sss_supervisor #(.WDOG_CYC(WD), .SHUT_CYC(SH), .SLOW_HALF_CYC(20), .FAST_HALF_CYC(6),
        .RESTART_CYC(16)) i_dut (.i_core_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_bresp(br), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rry), .s_axi_rdata(rdt),
        .s_axi_rresp(rr2), .i_cmd_valid(cv), .i_cmd_code(cc), .o_rsp_valid(rsv),
        .o_rsp_status(rss), .i_mains_ok(mains), .i_batt_low(low), .i_abort_sw(abt),
        .i_seq_done(done), .o_seq_start(st), .o_seq_running(run), .o_out_en(oe),
        .o_hw_rst(hr), .o_online(onl), .o_abort_ind(ai), .o_power_led(led),
        .o_shutdown(sd), .o_irq(irq));
    sss_host_model h (.i_core_clk(clk), .i_rsp_valid(rsv), .i_rsp_status(rss),
        .o_cmd_valid(cv), .o_cmd_code(cc), .o_last(last));
    initial forever #2 clk = ~clk;
    // event counters: led edges, start grants, cycles spent in restart
    always @(posedge clk) begin
        lq <= led;
        if (led !== lq) tog <= tog + 1;
        if (st === 1'b1) starts <= starts + 1;
        if (hr === 1'b1) hrc <= hrc + 1;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // expected status word: failure flag, mains and online bits
    function logic [7:0] sw(input logic f, input logic m, input logic o);
        return {f, 4'h0, m, 1'b0, o};
    endfunction
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {awv, wv, awa, wd} <= {2'b11, a, d};
        do @(posedge clk); while (!(awr && wrd));
        {awv, wv, bry} <= 3'b001;
        do @(posedge clk); while (bv !== 1'b1);
        chk(br, 2'b00);
        bry <= 1'b0;
    endtask
    task rdw(input logic [7:0] a);
        @(posedge clk);
        {arv, ara} <= {1'b1, a};
        do @(posedge clk); while (arr !== 1'b1);
        {arv, rry} <= 2'b01;
        do @(posedge clk); while (rv !== 1'b1);
        {rd, rsp} = {rdt, rr2};
        rry <= 1'b0;
    endtask
    task k;
        wr(8'h00, $urandom);
    endtask
    task final_report;
        $display("checks=%0d bad=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cyc(30000);
        bad_count++;
        final_report();
    end
    initial begin
        void'($urandom(41));
        cyc(10);
        rst <= 1'b0;
        wr(8'h0c, 32'h7);
        h.send(SSS_CMD_GO_ONLINE);
        cyc(2);
        chk(ai, 1'b1);
        abt <= 1'b1;
        cyc(3);
        chk(ai, 1'b0);
        abt <= 1'b0;
        h.send(SSS_CMD_GO_ONLINE);
        n0 = hrc;
        repeat (8) begin
            cyc(100 + $urandom % 800);
            k();
        end
        chk(hrc - n0, 0);
        for (int i = 0; i < 1200 && hr !== 1'b1; i++) cyc(1);
        chk({oe, onl, ai}, 3'b000);
        for (int i = 0; i < 40 && hr !== 1'b0; i++) cyc(1);
        cyc(2);
        chk({onl, irq}, 2'b11);
        rdw(8'h04);
        chk(rd, sw(1'b1, 1'b1, 1'b1));
        h.send(SSS_CMD_STATUS_QUERY_COMMAND);
        cyc(2);
        chk(last, sw(1'b1, 1'b1, 1'b1));
        wr(8'h08, 32'h1);
        wr(8'h0c, 32'h5);
        chk(irq, 1'b0);
        s0 = starts;
        mains <= 1'b0;
        h.send(SSS_CMD_START_SEQ);
        cyc(3);
        chk({starts - s0, onl, irq}, 2'b10);
        wr(8'h0c, 32'h7);
        chk(irq, 1'b1);
        wr(8'h08, 32'h2);
        mains <= 1'b1;
        h.send(SSS_CMD_START_SEQ);
        cyc(3);
        mains <= 1'b0;
        k();
        cyc(400);
        chk({starts - s0, run, sd, onl}, 4'hd);
        for (int i = 0; i < 3; i++) begin
            k();
            {mains, low} <= {i < 2, i > 0};
            cyc(4);
            n0 = tog;
            cyc(120);
            if (hf[i] == 0) chk({led, 8'(tog - n0)}, 9'h100);
            else chk((tog - n0) * hf[i] / 12 / 10, 1);
        end
        done <= 1'b1;
        cyc(2);
        {done, mains, low} <= 3'b000;
        k();
        h.send(SSS_CMD_STATUS_QUERY_COMMAND);
        cyc(SH - 40);
        chk({sd, led, onl}, 3'b001);
        cyc(80);
        chk(sd, 1'b1);
        rst <= 1'b1;
        cyc(10);
        rst <= 1'b0;
        rdw(8'h10);
        chk(rsp, 2'b11);
        chk(rd, 32'h0);
        cyc(SH - 60);
        chk({sd, onl}, 2'b00);
        cyc(80);
        chk(sd, 1'b1);
        final_report();
    end
endmodule // test_sss_supervisor
